// >>> hw/port_mux_pkg.sv
// Notes on behaviour
// - Input, pull-up off, no alternate function: pin floats, no pull-up.
// - Input with group pull-up select set: internal pull-up connected.
// - Converter select codes 1011b, 1101b, 1111b route P1_1..P1_3 to analog 9..11.
// - Output mode drive-strength bit 1 gives high drive, else normal drive.
// - Active serial mode, open-drain off: transmit pin is push-pull, direction ignored.
// - Active serial mode, open-drain on: transmit pin is N-channel open drain.
// - Synchronous internal-clock pattern drives serial clock out on P1_6.
// - External clock selected and direction 0: serial clock taken from P1_6.
// - Oscillator bits 1,0,1: buffer off, feedback on, external clock in, output high.
// - After reset every programmable port is in input mode.
// - Data read returns pin level for inputs and latch value for outputs.
// - Data write always updates the latch; latch drives pin in output mode.
// - Peripheral outputs ignore direction; peripheral inputs other than SDA and SCL need direction 0.
`default_nettype none
package port_mux_pkg;
  localparam int PORT_WIDTH = 8;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] PORT3_IMPL = 8'hb8;
  localparam logic [7:0] PORT4_IMPL = 8'h20;
  localparam logic [3:0] ADC_SEL_AN9 = 4'hb;
  localparam logic [3:0] ADC_SEL_ANALOG_CHANNEL_TEN = 4'hd;
  localparam logic [3:0] ADC_SEL_ANALOG_CHANNEL_ELEVEN = 4'hf;
  localparam logic [2:0] SMD_OFF = 3'h0;
  localparam logic [2:0] SMD_SYNC = 3'h1;
  localparam logic [2:0] SMD_ASYNC7 = 3'h4;
  localparam logic [2:0] SMD_ASYNC8 = 3'h5;
  localparam logic [2:0] SMD_ASYNC9 = 3'h6;
  localparam int TX_BIT = 4;
  localparam int RX_BIT = 5;
  localparam int SCK_BIT = 6;
  localparam int TZ_BIT = 3;
  localparam int SDA_BIT = 4;
  localparam int SCL_BIT = 5;
  localparam int P3_CMP_LOW = 3;
  localparam int P4_PIN = 5;
  localparam logic [1:0] TZ_MODE_PORT = 2'h0;
  localparam logic [1:0] TZ_MODE_PWM = 2'h1;
  typedef enum logic [1:0] {osc_input_port_type_v, osc_run, osc_ext_in, osc_stop} osc_mode_type;
endpackage : port_mux_pkg
`default_nettype wire

// >>> hw/port_regs_if.sv
`default_nettype none
interface port_regs_if;
  logic [7:0] dir;
  logic [7:0] latch;
  modport owner(output dir, output latch);
  modport user(input dir, input latch);
endinterface : port_regs_if
`default_nettype wire

// >>> hw/port_bank_regs.sv
`default_nettype none
module port_bank_regs #(
  parameter logic [7:0] IMPL = 8'hff
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Software writes.
  input wire logic dir_we,
  input wire logic [7:0] dir_wdata,
  input wire logic data_we,
  input wire logic [7:0] data_wdata,
  // Register outputs.
  port_regs_if.owner regs
);
  import port_mux_pkg::*;
  logic [7:0] dir;
  logic [7:0] latch;
  logic [7:0] next_dir;
  logic [7:0] next_latch;
  always_comb begin
    next_dir = dir;
    next_latch = latch;
    if (dir_we) begin
      next_dir = dir_wdata & IMPL;
    end
    if (data_we) begin
      next_latch = data_wdata;
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dir <= DIR_RESET;
      latch <= LATCH_RESET;
    end else begin
      dir <= next_dir;
      latch <= next_latch;
    end
  end
  assign regs.dir = dir;
  assign regs.latch = latch;
endmodule : port_bank_regs
`default_nettype wire

// >>> hw/port_pin_function_mux.sv
`default_nettype none
module port_pin_function_mux (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Direction and data writes for ports 1, 3 and 4.
  input wire logic port1_dir_we,
  input wire logic port3_dir_we,
  input wire logic port4_dir_we,
  input wire logic [7:0] dir_wdata,
  input wire logic port1_data_we,
  input wire logic port3_data_we,
  input wire logic port4_data_we,
  input wire logic [7:0] data_wdata,
  // Configuration bits.
  input wire logic pullup_p1_lower_group,
  input wire logic pullup_p1_upper_group,
  input wire logic pullup_p3_3,
  input wire logic pullup_p3_upper_group,
  input wire logic pullup_p4_5,
  input wire logic [3:0] drive_strength_select,
  input wire logic [3:0] key_input_enables,
  input wire logic [3:0] analog_group_select,
  input wire logic [5:0] compare_output_enables,
  input wire logic [2:0] serial_mode_field,
  input wire logic serial_clock_direction,
  input wire logic open_drain_select,
  input wire logic [1:0] tz_mode,
  input wire logic tz_output_ctrl,
  input wire logic i2c_pin_enable,
  input wire logic osc_pin_select,
  input wire logic osc_stop_select,
  input wire logic main_osc_stop,
  // Peripheral outputs to pins.
  input wire logic [5:0] compare_out,
  input wire logic tz_out,
  input wire logic serial_tx,
  input wire logic serial_clk_out,
  input wire logic sda_out_en,
  input wire logic scl_out_en,
  // Port pins.
  input wire logic [7:0] port1_in,
  output logic [7:0] port1_out,
  output logic [7:0] port1_oe,
  input wire logic [7:0] port3_in,
  output logic [7:0] port3_out,
  output logic [7:0] port3_oe,
  input wire logic [7:0] port4_in,
  output logic [7:0] port4_out,
  output logic [7:0] port4_oe,
  output logic [7:0] port1_pullup,
  output logic [7:0] port3_pullup,
  output logic port4_pullup,
  output logic [3:0] port1_high_drive,
  // Peripheral inputs from pins.
  output logic [3:0] key_in,
  output logic key_valid,
  output logic analog_channel_nine,
  output logic analog_channel_ten,
  output logic analog_channel_eleven,
  output logic serial_rx,
  output logic serial_clk_in,
  output logic sda_in,
  output logic scl_in,
  // Oscillator pad control.
  output logic osc_buffer_on,
  output logic osc_feedback_on,
  output logic osc_ext_clock,
  output logic crystal_output_drive_high,
  // Data register reads.
  output logic [7:0] port1_rdata,
  output logic [7:0] port3_rdata,
  output logic [7:0] port4_rdata
);
  import port_mux_pkg::*;
  port_regs_if p1 ();
  port_regs_if p3 ();
  port_regs_if p4 ();
  port_bank_regs #(.IMPL(8'hff)) u_p1 (
    .mclk(mclk), .rst_b(rst_b), .dir_we(port1_dir_we), .dir_wdata(dir_wdata),
    .data_we(port1_data_we), .data_wdata(data_wdata), .regs(p1.owner));
  port_bank_regs #(.IMPL(PORT3_IMPL)) u_p3 (
    .mclk(mclk), .rst_b(rst_b), .dir_we(port3_dir_we), .dir_wdata(dir_wdata),
    .data_we(port3_data_we), .data_wdata(data_wdata), .regs(p3.owner));
  port_bank_regs #(.IMPL(PORT4_IMPL)) u_p4 (
    .mclk(mclk), .rst_b(rst_b), .dir_we(port4_dir_we), .dir_wdata(dir_wdata),
    .data_we(port4_data_we), .data_wdata(data_wdata), .regs(p4.owner));

  function automatic logic [7:0] read_mix(input logic [7:0] dir, input logic [7:0] latch,
                                          input logic [7:0] pins);
    read_mix = (dir & latch) | (~dir & pins);
  endfunction : read_mix

  logic serial_active;
  logic sync_int_clk;
  logic [7:0] claim1;
  logic [7:0] claim3;
  logic [7:0] next_p1_out, next_p1_oe, next_p3_out, next_p3_oe;
  logic [7:0] next_p1_pu, next_p3_pu;
  logic [7:0] p1_out_q, p1_oe_q, p3_out_q, p3_oe_q, p1_pu_q, p3_pu_q, p4_out_q, p4_oe_q;
  logic p4_pu_q;
  logic [3:0] hd_q;

  assign serial_active = (serial_mode_field == SMD_SYNC) || (serial_mode_field == SMD_ASYNC7)
      || (serial_mode_field == SMD_ASYNC8) || (serial_mode_field == SMD_ASYNC9);
  // Internal-clock output needs mode bit 2 low, mode bit 0 high and the internal clock selected.
  assign sync_int_clk = !serial_mode_field[2] && serial_mode_field[0]
      && !serial_clock_direction;

  always_comb begin
    next_p1_out = p1.latch;
    next_p1_oe = p1.dir;
    next_p3_out = p3.latch;
    next_p3_oe = p3.dir;
    claim1 = 8'h00;
    claim3 = 8'h00;
    for (int i = 0; i < 3; i++) begin
      if (compare_output_enables[i]) begin
        next_p1_out[i] = compare_out[i];
        next_p1_oe[i] = 1'b1;
        claim1[i] = 1'b1;
      end
    end
    if (tz_mode[1] || (tz_mode == TZ_MODE_PWM && !tz_output_ctrl)) begin
      next_p1_out[TZ_BIT] = tz_out;
      next_p1_oe[TZ_BIT] = 1'b1;
      claim1[TZ_BIT] = 1'b1;
    end
    if (serial_active) begin
      claim1[TX_BIT] = 1'b1;
      if (open_drain_select) begin
        next_p1_out[TX_BIT] = 1'b0;
        next_p1_oe[TX_BIT] = !serial_tx;
      end else begin
        next_p1_out[TX_BIT] = serial_tx;
        next_p1_oe[TX_BIT] = 1'b1;
      end
    end
    if (sync_int_clk) begin
      next_p1_out[SCK_BIT] = serial_clk_out;
      next_p1_oe[SCK_BIT] = 1'b1;
      claim1[SCK_BIT] = 1'b1;
    end
    for (int i = 0; i < 3; i++) begin
      if (compare_output_enables[3+i] && !(i > 0 && i2c_pin_enable)) begin
        next_p3_out[P3_CMP_LOW+i] = compare_out[3+i];
        next_p3_oe[P3_CMP_LOW+i] = 1'b1;
        claim3[P3_CMP_LOW+i] = 1'b1;
      end
    end
    if (i2c_pin_enable) begin
      next_p3_out[SDA_BIT] = 1'b0;
      next_p3_oe[SDA_BIT] = sda_out_en;
      next_p3_out[SCL_BIT] = 1'b0;
      next_p3_oe[SCL_BIT] = scl_out_en;
      claim3[SDA_BIT] = 1'b1;
      claim3[SCL_BIT] = 1'b1;
    end
    // Pull-ups only on undriven, unclaimed input pins.
    next_p1_pu = {{4{pullup_p1_upper_group}}, {4{pullup_p1_lower_group}}}
        & ~p1.dir & ~claim1;
    next_p3_pu = {pullup_p3_upper_group, 1'b0, {2{pullup_p3_upper_group}}, pullup_p3_3, 3'h0}
        & ~p3.dir & ~claim3 & PORT3_IMPL;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      p1_out_q <= 8'h00;
      p1_oe_q <= 8'h00;
      p3_out_q <= 8'h00;
      p3_oe_q <= 8'h00;
      p4_out_q <= 8'h00;
      p4_oe_q <= 8'h00;
      p1_pu_q <= 8'h00;
      p3_pu_q <= 8'h00;
      p4_pu_q <= 1'b0;
      hd_q <= 4'h0;
    end else begin
      p1_out_q <= next_p1_out;
      p1_oe_q <= next_p1_oe;
      p3_out_q <= next_p3_out;
      p3_oe_q <= next_p3_oe;
      p4_out_q <= p4.latch;
      p4_oe_q <= p4.dir;
      p1_pu_q <= next_p1_pu;
      p3_pu_q <= next_p3_pu;
      p4_pu_q <= pullup_p4_5 & ~p4.dir[P4_PIN];
      hd_q <= drive_strength_select & next_p1_oe[3:0];
    end
  end

  assign port1_out = p1_out_q;
  assign port1_oe = p1_oe_q;
  assign port3_out = p3_out_q;
  assign port3_oe = p3_oe_q;
  assign port4_out = p4_out_q;
  assign port4_oe = p4_oe_q;
  assign port1_pullup = p1_pu_q;
  assign port3_pullup = p3_pu_q;
  assign port4_pullup = p4_pu_q;
  assign port1_high_drive = hd_q;

  // Peripheral inputs other than SDA and SCL need the direction bit at 0.
  assign key_in = port1_in[3:0] & ~p1.dir[3:0] & key_input_enables;
  assign key_valid = |(key_input_enables & ~p1.dir[3:0]);
  assign analog_channel_nine = !p1.dir[1] && !next_p1_pu[1]
      && analog_group_select == ADC_SEL_AN9;
  assign analog_channel_ten = !p1.dir[2] && !next_p1_pu[2]
      && analog_group_select == ADC_SEL_ANALOG_CHANNEL_TEN;
  assign analog_channel_eleven = !p1.dir[3] && !next_p1_pu[3] && tz_mode == TZ_MODE_PORT
      && analog_group_select == ADC_SEL_ANALOG_CHANNEL_ELEVEN;
  assign serial_rx = port1_in[RX_BIT] | p1.dir[RX_BIT];
  assign serial_clk_in = serial_clock_direction && !p1.dir[SCK_BIT]
      && port1_in[SCK_BIT];
  assign sda_in = i2c_pin_enable ? port3_in[SDA_BIT] : 1'b1;
  assign scl_in = i2c_pin_enable ? port3_in[SCL_BIT] : 1'b1;

  // Oscillator pad modes.
  assign osc_buffer_on = osc_pin_select && !osc_stop_select && !main_osc_stop;
  assign osc_feedback_on = osc_pin_select && !osc_stop_select;
  assign osc_ext_clock = osc_pin_select && !osc_stop_select && main_osc_stop;
  assign crystal_output_drive_high = osc_ext_clock;

  assign port1_rdata = read_mix(p1.dir, p1.latch, port1_in);
  assign port3_rdata = read_mix(p3.dir, p3.latch, port3_in) & PORT3_IMPL;
  assign port4_rdata = osc_pin_select ? (read_mix(p4.dir, p4.latch, port4_in) & PORT4_IMPL)
      : ((read_mix(p4.dir, p4.latch, port4_in) & PORT4_IMPL) | (port4_in & 8'hc0));
endmodule : port_pin_function_mux
`default_nettype wire

// >>> bench/port_mux_asserts.sv
`default_nettype none
module port_mux_asserts (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Configuration and peripheral levels.
  input wire logic [5:0] compare_output_enables,
  input wire logic [2:0] serial_mode_field,
  input wire logic serial_clock_direction,
  input wire logic open_drain_select,
  input wire logic i2c_pin_enable,
  input wire logic osc_pin_select,
  input wire logic osc_stop_select,
  input wire logic main_osc_stop,
  input wire logic [5:0] compare_out,
  input wire logic serial_tx,
  input wire logic serial_clk_out,
  input wire logic sda_out_en,
  input wire logic scl_out_en,
  // Pad and oscillator outputs.
  input wire logic [7:0] port1_out,
  input wire logic [7:0] port1_oe,
  input wire logic [7:0] port3_out,
  input wire logic [7:0] port3_oe,
  input wire logic osc_buffer_on,
  input wire logic osc_feedback_on,
  input wire logic osc_ext_clock,
  input wire logic crystal_output_drive_high
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ser_on;
  assign ser_on = serial_mode_field inside {3'h1, 3'h4, 3'h5, 3'h6};
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_reset_inputs: assert property ($rose(rst_b) |-> (port1_oe | port3_oe) == 8'h00)
    else $error("pin driven after reset");
  a_cmp_p10: assert property (compare_output_enables[0] |=> port1_oe[0]
    && port1_out[0] == $past(compare_out[0])) else $error("compare not on P1_0");
  a_cmp_p33: assert property (compare_output_enables[3] ##1 1'b1 |-> port3_oe[3]
    && port3_out[3] == $past(compare_out[3])) else $error("compare not on P3_3");
  a_tx_push: assert property (ser_on && !open_drain_select |=> port1_oe[4]
    && port1_out[4] == $past(serial_tx)) else $error("tx not push-pull");
  a_tx_open: assert property (ser_on && open_drain_select |=> !port1_out[4]
    && port1_oe[4] == !$past(serial_tx)) else $error("tx not open drain");
  a_clk_out: assert property (serial_mode_field == 3'h1 && !serial_clock_direction
    |=> port1_oe[6] && port1_out[6] == $past(serial_clk_out)) else $error("clock not out");
  a_i2c_pins: assert property (i2c_pin_enable |=> port3_out[5:4] == 2'b00
    && port3_oe[4] == $past(sda_out_en) && port3_oe[5] == $past(scl_out_en))
    else $error("i2c pins wrong");
  a_osc_ext: assert property (osc_pin_select && !osc_stop_select && main_osc_stop
    |-> !osc_buffer_on && osc_feedback_on && osc_ext_clock && crystal_output_drive_high)
    else $error("oscillator pads wrong");
  c_tx_open: cover property (ser_on && open_drain_select);
  c_i2c: cover property (i2c_pin_enable && compare_output_enables[4]);
  c_clk: cover property (serial_mode_field == 3'h1 && !serial_clock_direction);
endmodule : port_mux_asserts
bind port_pin_function_mux port_mux_asserts i_port_mux_asserts (.*);
`default_nettype wire

// >>> bench/pin_world.sv
`default_nettype none
module pin_world (
  // Pad drive from the mux.
  input wire logic [7:0] out,
  input wire logic [7:0] oe,
  input wire logic [7:0] pull,
  // Board level and resolved pin.
  input wire logic [7:0] ext,
  output logic [7:0] lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  assign lvl = (oe & out) | (~oe & pull) | (~oe & ~pull & ext);
endmodule : pin_world
`default_nettype wire

// >>> bench/testbench.sv
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import port_mux_pkg::*;
  logic mclk, rst_b, port1_dir_we, port3_dir_we, port4_dir_we, port1_data_we, port3_data_we;
  logic port4_data_we, pullup_p1_lower_group, pullup_p1_upper_group, pullup_p3_3, pullup_p4_5;
  logic pullup_p3_upper_group, serial_clock_direction, open_drain_select, tz_output_ctrl;
  logic i2c_pin_enable, osc_pin_select, osc_stop_select, main_osc_stop, tz_out, serial_tx;
  logic serial_clk_out, sda_out_en, scl_out_en, port4_pullup, key_valid, serial_rx, sda_in;
  logic analog_channel_nine, analog_channel_ten, analog_channel_eleven, serial_clk_in, scl_in;
  logic osc_buffer_on, osc_feedback_on, osc_ext_clock, crystal_output_drive_high;
  logic [1:0] tz_mode;
  logic [2:0] serial_mode_field;
  logic [3:0] drive_strength_select, key_input_enables, analog_group_select, port1_high_drive;
  logic [3:0] key_in;
  logic [5:0] compare_output_enables, compare_out;
  logic [7:0] dir_wdata, data_wdata, port1_in, port3_in, port4_in, port1_out, port1_oe;
  logic [7:0] port3_out, port3_oe, port4_out, port4_oe, port1_pullup, port3_pullup;
  logic [7:0] port1_rdata, port3_rdata, port4_rdata, ext1, ext3, ext4;
  logic [3:0] osc_pads;
  logic [2:0] analog_hits;
  logic [1:0] exp_tx;
  assign osc_pads = {osc_buffer_on, osc_feedback_on, osc_ext_clock, crystal_output_drive_high};
  assign analog_hits = {analog_channel_eleven, analog_channel_ten, analog_channel_nine};
  int err_count = 0;
  int num_checks = 0;
  port_pin_function_mux i_port_pin_function_mux (.*);
  pin_world i_p1 (.out(port1_out), .oe(port1_oe), .pull(port1_pullup), .ext(ext1), .lvl(port1_in));
  pin_world i_p3 (.out(port3_out), .oe(port3_oe), .pull(port3_pullup), .ext(ext3), .lvl(port3_in));
  pin_world i_p4 (.out(port4_out), .oe(port4_oe), .pull({2'b00, port4_pullup, 5'b00000}),
    .ext(ext4), .lvl(port4_in));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick
  task automatic wr(input logic is_dir, input logic [2:0] sel, input logic [7:0] v);
    dir_wdata = v;
    data_wdata = v;
    {port4_dir_we, port3_dir_we, port1_dir_we} = is_dir ? sel : 3'b000;
    {port4_data_we, port3_data_we, port1_data_we} = is_dir ? 3'b000 : sel;
    tick(1);
    {port4_dir_we, port3_dir_we, port1_dir_we} = 3'b000;
    {port4_data_we, port3_data_we, port1_data_we} = 3'b000;
    tick(1);
  endtask : wr
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #40000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    {rst_b, port1_dir_we, port3_dir_we, port4_dir_we, port1_data_we, port3_data_we,
     port4_data_we, pullup_p1_lower_group, pullup_p1_upper_group, pullup_p3_3, pullup_p4_5,
     pullup_p3_upper_group, serial_clock_direction, open_drain_select, tz_output_ctrl,
     i2c_pin_enable, osc_pin_select, osc_stop_select, main_osc_stop, tz_out, serial_tx,
     serial_clk_out, sda_out_en, scl_out_en, tz_mode, serial_mode_field, drive_strength_select,
     key_input_enables, analog_group_select, compare_output_enables, compare_out, dir_wdata,
     data_wdata, ext1, ext3, ext4} = '0;
    tick(8);
    rst_b = 1'b1;
    ext1 = 8'ha5;
    tick(1);
    `CHK("p1 oe", 8'h00, port1_oe)
    `CHK("p1 pullup", 8'h00, port1_pullup)
    `CHK("p1 read", 8'ha5, port1_rdata)
    pullup_p1_lower_group = 1'b1;
    ext1 = 8'h00;
    tick(1);
    `CHK("p1 pullup", 8'h0f, port1_pullup)
    pullup_p1_lower_group = 1'b0;
    drive_strength_select = 4'ha;
    wr(1'b0, 3'b001, 8'h3c);
    wr(1'b1, 3'b111, 8'h0f);
    tick(1);
    `CHK("p1 oe", 8'h0f, port1_oe)
    `CHK("p1 out", 4'hc, port1_out[3:0])
    `CHK("p1 read", 8'h0c, port1_rdata)
    `CHK("high drive", 4'ha, port1_high_drive)
    `CHK("p3 oe", PORT3_IMPL & 8'h0f, port3_oe)
    wr(1'b1, 3'b111, 8'h00);
    tick(1);
    for (int i = 0; i < 3; i++) begin
      analog_group_select = (i == 0) ? ADC_SEL_AN9 : (i == 1) ? ADC_SEL_ANALOG_CHANNEL_TEN : ADC_SEL_ANALOG_CHANNEL_ELEVEN;
      ext1 = 8'h02 << i;
      tick(1);
      `CHK("analog", 3'b001 << i, analog_hits)
    end
    for (int m = 0; m < 8; m++) begin
      for (int od = 0; od < 2; od++) begin
        if (m inside {2, 3, 7}) continue;
        serial_mode_field = m[2:0];
        open_drain_select = od[0];
        serial_tx = m[2];
        tick(1);
        // Mode zero leaves the pin to the port; latch bit 4 still holds the earlier write.
        exp_tx = (m == 0) ? 2'b01 : od[0] ? {~serial_tx, 1'b0} : {1'b1, serial_tx};
        `CHK("tx pin", exp_tx, {port1_oe[4], port1_out[4]})
        `CHK("clk idle", m == 1, port1_oe[6])
      end
    end
    serial_mode_field = SMD_SYNC;
    serial_clk_out = 1'b1;
    tick(1);
    `CHK("clk pin", 2'b11, {port1_oe[6], port1_out[6]})
    serial_clock_direction = 1'b1;
    ext1 = 8'h40;
    tick(1);
    `CHK("clk in", 1'b1, serial_clk_in)
    `CHK("rx in", 1'b0, serial_rx)
    serial_mode_field = SMD_OFF;
    compare_output_enables = 6'h3f;
    compare_out = 6'h0d;
    i2c_pin_enable = 1'b1;
    sda_out_en = 1'b1;
    tick(1);
    `CHK("p1 cmp", 6'h3d, {port1_oe[2:0], port1_out[2:0]})
    `CHK("p3 pins", 6'h19, {port3_oe[5:3], port3_out[5:3]})
    {osc_pin_select, osc_stop_select, main_osc_stop} = 3'b101;
    tick(1);
    `CHK("osc", 4'h7, osc_pads)
    main_osc_stop = 1'b0;
    ext3 = 8'h20;
    tick(1);
    `CHK("osc run", 4'hc, osc_pads)
    `CHK("i2c in", 2'b01, {sda_in, scl_in})
    compare_output_enables = 6'h00;
    i2c_pin_enable = 1'b0;
    key_input_enables = 4'h6;
    ext1 = 8'h0c;
    {pullup_p3_upper_group, pullup_p3_3, pullup_p4_5} = 3'b111;
    tick(1);
    `CHK("key", 5'h14, {key_valid, key_in})
    `CHK("pullups", 9'h1b8, {port4_pullup, port3_pullup})
    `CHK("p3 read", 8'hb8, port3_rdata)
    `CHK("i2c idle", 2'b11, {sda_in, scl_in})
    wr(1'b0, 3'b100, 8'hff);
    wr(1'b1, 3'b101, 8'h24);
    tz_mode = TZ_MODE_PWM;
    tz_out = 1'b1;
    tick(1);
    `CHK("key dir", 5'h10, {key_valid, key_in})
    `CHK("rx out", 1'b1, serial_rx)
    `CHK("tz pin", 2'b11, {port1_oe[3], port1_out[3]})
    `CHK("tz drive", 4'h8, port1_high_drive)
    `CHK("p4 pin", 16'h2020, {port4_oe, port4_rdata})
    tz_output_ctrl = 1'b1;
    osc_pin_select = 1'b0;
    ext4 = 8'hc0;
    tick(1);
    `CHK("tz off", 1'b0, port1_oe[3])
    `CHK("p4 read", 8'he0, port4_rdata)
    `CHK("osc port", 4'h0, osc_pads)
    tz_mode = TZ_MODE_PORT;
    rst_b = 1'b0;
    tick(1);
    `CHK("reset oe", 24'h000000, {port4_oe, port3_oe, port1_oe})
    rst_b = 1'b1;
    tick(1);
    `CHK("dir cleared", 16'h0000, {port4_oe, port1_oe})
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
